// file: common/tsc_pkg.sv
/*
  Shared constants for the secondary-oscillator timer: register map, control
  field positions, reset values, power-mode codes and the prescale decode.
  Assumes a byte-wide register port and a core clock equal to the oscillator
  clock, so one instruction cycle lasts four core clocks.
*/
package tsc_pkg;

  // --------------------------------------------------------------------
  // Register map (index on the byte-wide register port)
  // --------------------------------------------------------------------
  localparam logic [2:0] ADDR_CTRL    = 3'h0;  // counter_control
  localparam logic [2:0] ADDR_CNT_LO  = 3'h1;  // count_low_byte
  localparam logic [2:0] ADDR_CNT_HI  = 3'h2;  // count_high_byte
  localparam logic [2:0] ADDR_FLAGS   = 3'h3;  // periph_flags_1, read clears
  localparam logic [2:0] ADDR_ENABLES = 3'h4;  // periph_enables_1
  localparam logic [2:0] ADDR_OSC     = 3'h5;  // osc_control
  localparam logic [2:0] ADDR_PDIR    = 3'h6;  // port_direction, 1 = input
  localparam logic [2:0] ADDR_PDATA   = 3'h7;  // port data latch / pin read

  // --------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------
  localparam int CTRL_ON     = 0;  // counter_on
  localparam int CTRL_SRC    = 1;  // count_source_sel
  localparam int CTRL_NOSYNC = 2;  // ext_sync_bypass
  localparam int CTRL_OSCEN  = 3;  // sec_osc_enable
  localparam int CTRL_PS_LO  = 4;  // input_prescale_sel low bit
  localparam int CTRL_PS_HI  = 5;  // input_prescale_sel high bit
  localparam int CTRL_RUN    = 6;  // sec_osc_is_sysclk, read only
  localparam int CTRL_WIDE   = 7;  // wide_access_sel
  localparam int FLAG_OVF    = 0;  // overflow_flag / overflow_irq_en
  localparam int OSC_IDLE    = 7;  // idle_on_sleep

  // --------------------------------------------------------------------
  // Reset values, write masks and encodings
  // --------------------------------------------------------------------
  localparam logic [7:0]  CTRL_RST    = 8'h00;
  localparam logic [7:0]  CTRL_WMASK  = 8'hbf;
  localparam logic [7:0]  FLAGS_RST   = 8'h00;
  localparam logic [7:0]  ENABLES_RST = 8'h00;
  localparam logic [7:0]  OSC_RST     = 8'h00;
  localparam logic [1:0]  PDIR_RST    = 2'h3;
  localparam logic [1:0]  PDATA_RST   = 2'h0;
  localparam logic [15:0] CNT_RST     = 16'h0000;
  localparam logic [15:0] CNT_MAX     = 16'hffff;
  localparam logic [1:0]  SCS_SEC     = 2'h1;
  localparam logic [1:0]  INSTR_DIV   = 2'h3;  // Four core clocks per instruction

  // --------------------------------------------------------------------
  // Power modes, one-hot
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    TSC_PRI_RUN  = 3'h1,
    TSC_SECONDARY_RUN_MODE  = 3'h2,
    TSC_SECONDARY_IDLE_MODE = 3'h4
  } tsc_mode_t;

  // Prescale select to counter mask: 1:1, 1:2, 1:4, 1:8
  function automatic logic [2:0] tsc_ratio_mask(input logic [1:0] sel);
    case (sel)
      2'h0:    tsc_ratio_mask = 3'h0;
      2'h1:    tsc_ratio_mask = 3'h1;
      2'h2:    tsc_ratio_mask = 3'h3;
      default: tsc_ratio_mask = 3'h7;
    endcase
  endfunction

endpackage

// file: src/tsc_sync2.sv
/*
  Two-stage level synchroniser into the core clock domain.
  Assumes the input may change at any time; only the second stage is read.
*/
module tsc_sync2 (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_r;

  // ------------------------------------------------------------------
  // Two flops in series
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta_r   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// file: src/tsc_prescale.sv
/*
  Input prescaler: passes one tick in 1, 2, 4 or 8.
  Assumes tick_in is a one-cycle pulse in the core clock domain.
*/
module tsc_prescale (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       tick_in,
  input  wire logic [1:0] ratio_sel,
  input  wire logic       clear,
  output logic            tick_out
);
  import tsc_pkg::*;

  logic [2:0] cnt_r;
  logic [2:0] mask;

  // ------------------------------------------------------------------
  // Ratio counter, cleared by software
  // ------------------------------------------------------------------
  assign mask     = tsc_ratio_mask(ratio_sel);
  assign tick_out = tick_in && ((cnt_r & mask) == mask);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 3'h0;
    end else if (clear) begin
      cnt_r <= 3'h0;
    end else if (tick_in) begin
      cnt_r <= cnt_r + 3'h1;
    end
  end

  chk_psc_ratio_gap: assert property (@(posedge core_clk) disable iff (!nrst)
    (tick_out && ratio_sel == 2'h3 && !clear) |=> !tick_out [*7])
    else $error("prescale 1:8 passed ticks too close");

endmodule

// file: src/tsc_top.sv
/*
  Sixteen-bit counter with secondary crystal oscillator control, power-mode
  tracking, overflow interrupt and two shared oscillator pins.
  Assumes core_clk is the oscillator clock, byte register port on core_clk,
  and sleep, fail-safe and fail inputs from logic on the same clock.
*/
// Behaviour
// - sixteen-bit counter, overflow on all-ones to zero
// - on bit enables counting, clear holds value
// - source bit picks instruction clock or external
// - advance per instruction cycle or external rising edge
// - sync bit chooses synchronised or bypass external path
// - prescale field gives 1, 2, 4, 8
// - oscillator enable bit powers the amplifier
// - wide bit picks sixteen-bit or byte access
// - status bit shows oscillator supplies system clock
// - enabled oscillator forces pins input, reads zero
// - oscillator keeps running through every power mode
// - clock select 01 enters secondary run
// - sleep without idle enable enters secondary idle
// - monitored oscillator failure updates the status bit
// - low read buffers high, low write loads it
// - overflow sets sticky flag, enable gates interrupt
// - high buffer write keeps prescaler, low clears
module tsc_top (
  input  wire logic              core_clk,
  input  wire logic              nrst,
  input  wire logic [2:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [7:0]             reg_rdata,
  input  wire logic              sleep_exec,
  input  wire logic              fscm_enable,
  input  wire logic              sec_osc_fail,
  input  wire logic              sec_osc_in_pin_i,
  output logic                   sec_osc_in_pin_o,
  output logic                   sec_osc_in_pin_oe,
  input  wire logic              sec_osc_out_ext_clk_pin_i,
  output logic                   sec_osc_out_ext_clk_pin_o,
  output logic                   sec_osc_out_ext_clk_pin_oe,
  output logic                   sec_osc_amp_en,
  output logic                   irq,
  output logic                   sec_osc_is_sysclk,
  output tsc_pkg::tsc_mode_t     power_mode
);
  import tsc_pkg::*;

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic [7:0]  ctrl_r;
  logic [15:0] cnt_r;
  logic [7:0]  hibuf_r;
  logic [7:0]  flags_r;
  logic [7:0]  enables_r;
  logic [7:0]  osc_r;
  logic [1:0]  pdir_r;
  logic [1:0]  pdata_r;
  logic [1:0]  instr_cnt_r;
  logic        ext_prev_r;
  tsc_mode_t   mode_r;
  tsc_mode_t   mode_nxt;
  logic        in_pin_q;
  logic        ext_pin_q;
  logic        ext_resync_q;
  logic        ext_lvl;
  logic        ext_rise;
  logic        instr_tick;
  logic        src_tick;
  logic        cnt_inc;
  logic        psc_clr;
  logic        wr_ctrl;
  logic        wr_lo;
  logic        wr_hi;
  logic        wr_osc;
  logic        rd_lo;
  logic        rd_flags;
  logic        cnt_wr;
  logic        ovf_evt;
  logic        fail_evt;
  logic        wide;
  logic [7:0]  rd_mux;

  // ------------------------------------------------------------------
  // Register port decode
  // ------------------------------------------------------------------
  assign wr_ctrl  = reg_wr && reg_addr == ADDR_CTRL;
  assign wr_lo    = reg_wr && reg_addr == ADDR_CNT_LO;
  assign wr_hi    = reg_wr && reg_addr == ADDR_CNT_HI;
  assign wr_osc   = reg_wr && reg_addr == ADDR_OSC;
  assign rd_lo    = reg_rd && reg_addr == ADDR_CNT_LO;
  assign rd_flags = reg_rd && reg_addr == ADDR_FLAGS;
  assign wide     = ctrl_r[CTRL_WIDE];
  assign cnt_wr   = wr_lo || (wr_hi && !wide);
  assign psc_clr  = wr_lo;

  // ------------------------------------------------------------------
  // Pin synchronisers and external edge path
  // ------------------------------------------------------------------
  tsc_sync2 u_sync_in (
    .core_clk (core_clk),
    .nrst     (nrst),
    .async_in (sec_osc_in_pin_i),
    .sync_out (in_pin_q)
  );

  tsc_sync2 u_sync_ext (
    .core_clk (core_clk),
    .nrst     (nrst),
    .async_in (sec_osc_out_ext_clk_pin_i),
    .sync_out (ext_pin_q)
  );

  // Extra alignment stages when synchronised counting is chosen
  tsc_sync2 u_resync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .async_in (ext_pin_q),
    .sync_out (ext_resync_q)
  );

  assign ext_lvl  = ctrl_r[CTRL_NOSYNC] ? ext_pin_q : ext_resync_q;
  assign ext_rise = ext_lvl && !ext_prev_r;

  // Edge detector history
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ext_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= ext_lvl;
    end
  end

  // ------------------------------------------------------------------
  // Instruction-cycle tick, one in four core clocks
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      instr_cnt_r <= 2'h0;
    end else begin
      instr_cnt_r <= instr_cnt_r + 2'h1;
    end
  end

  assign instr_tick = instr_cnt_r == INSTR_DIV;

  // Source choice and run gate ahead of the prescaler
  assign src_tick = (ctrl_r[CTRL_SRC] ? ext_rise : instr_tick)
                    && ctrl_r[CTRL_ON];

  tsc_prescale u_psc (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .tick_in   (src_tick),
    .ratio_sel (ctrl_r[CTRL_PS_HI:CTRL_PS_LO]),
    .clear     (psc_clr),
    .tick_out  (cnt_inc)
  );

  // ------------------------------------------------------------------
  // Control register; status bit is never stored from a write
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= reg_wdata & CTRL_WMASK;
    end
  end

  // ------------------------------------------------------------------
  // Counter: a write wins over a same-cycle increment
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= CNT_RST;
    end else if (wr_lo && wide) begin
      cnt_r <= {hibuf_r, reg_wdata};
    end else if (wr_lo) begin
      cnt_r[7:0] <= reg_wdata;
    end else if (wr_hi && !wide) begin
      cnt_r[15:8] <= reg_wdata;
    end else if (cnt_inc) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  // High-byte buffer for wide access
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hibuf_r <= 8'h00;
    end else if (wr_hi && wide) begin
      hibuf_r <= reg_wdata;
    end else if (rd_lo && wide) begin
      hibuf_r <= cnt_r[15:8];
    end
  end

  // ------------------------------------------------------------------
  // Overflow flag and interrupt; a new overflow beats a clearing read
  // ------------------------------------------------------------------
  assign ovf_evt = cnt_inc && !cnt_wr && cnt_r == CNT_MAX;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flags_r <= FLAGS_RST;
    end else begin
      flags_r[FLAG_OVF] <= ovf_evt || (flags_r[FLAG_OVF] && !rd_flags);
    end
  end

  // Enable register and interrupt level
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      enables_r <= ENABLES_RST;
      irq       <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == ADDR_ENABLES) begin
        enables_r <= {7'h00, reg_wdata[FLAG_OVF]};
      end
      irq <= |(flags_r & enables_r);
    end
  end

  // ------------------------------------------------------------------
  // Oscillator control and power-mode tracking
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      osc_r <= OSC_RST;
    end else if (wr_osc) begin
      osc_r <= {reg_wdata[OSC_IDLE], 5'h00, reg_wdata[1:0]};
    end
  end

  assign fail_evt = fscm_enable && sec_osc_fail;

  // Next power mode
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      TSC_PRI_RUN: begin
        if (wr_osc && reg_wdata[1:0] == SCS_SEC) begin
          mode_nxt = TSC_SECONDARY_RUN_MODE;
        end
      end
      TSC_SECONDARY_RUN_MODE: begin
        if (fail_evt) begin
          mode_nxt = TSC_PRI_RUN;
        end else if (wr_osc && reg_wdata[1:0] != SCS_SEC) begin
          mode_nxt = TSC_PRI_RUN;
        end else if (sleep_exec && !osc_r[OSC_IDLE]) begin
          mode_nxt = TSC_SECONDARY_IDLE_MODE;
        end
      end
      TSC_SECONDARY_IDLE_MODE: begin
        if (fail_evt) begin
          mode_nxt = TSC_PRI_RUN;
        end else if (irq) begin
          mode_nxt = TSC_SECONDARY_RUN_MODE;
        end
      end
      default: mode_nxt = TSC_PRI_RUN;
    endcase
  end

  // Mode, clock status and amplifier enable; sleep leaves the amplifier on
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mode_r            <= TSC_PRI_RUN;
      power_mode        <= TSC_PRI_RUN;
      sec_osc_is_sysclk <= 1'b0;
      sec_osc_amp_en    <= 1'b0;
    end else begin
      mode_r            <= mode_nxt;
      power_mode        <= mode_r;
      sec_osc_is_sysclk <= mode_r != TSC_PRI_RUN;
      sec_osc_amp_en    <= ctrl_r[CTRL_OSCEN];
    end
  end

  // ------------------------------------------------------------------
  // Shared pins: the oscillator takes them over as inputs
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pdir_r                     <= PDIR_RST;
      pdata_r                    <= PDATA_RST;
      sec_osc_in_pin_o           <= 1'b0;
      sec_osc_in_pin_oe          <= 1'b0;
      sec_osc_out_ext_clk_pin_o  <= 1'b0;
      sec_osc_out_ext_clk_pin_oe <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == ADDR_PDIR) begin
        pdir_r <= reg_wdata[1:0];
      end
      if (reg_wr && reg_addr == ADDR_PDATA) begin
        pdata_r <= reg_wdata[1:0];
      end
      sec_osc_in_pin_o           <= pdata_r[0];
      sec_osc_out_ext_clk_pin_o  <= pdata_r[1];
      sec_osc_in_pin_oe          <= !pdir_r[0] && !ctrl_r[CTRL_OSCEN];
      sec_osc_out_ext_clk_pin_oe <= !pdir_r[1] && !ctrl_r[CTRL_OSCEN];
    end
  end

  // ------------------------------------------------------------------
  // Read data, valid the cycle after the strobe
  // ------------------------------------------------------------------
  always_comb begin
    case (reg_addr)
      ADDR_CTRL:    rd_mux = {ctrl_r[7], sec_osc_is_sysclk, ctrl_r[5:0]};
      ADDR_CNT_LO:  rd_mux = cnt_r[7:0];
      ADDR_CNT_HI:  rd_mux = wide ? hibuf_r : cnt_r[15:8];
      ADDR_FLAGS:   rd_mux = flags_r;
      ADDR_ENABLES: rd_mux = enables_r;
      ADDR_OSC:     rd_mux = osc_r;
      ADDR_PDIR:    rd_mux = {6'h00, pdir_r};
      ADDR_PDATA:   rd_mux = ctrl_r[CTRL_OSCEN] ? 8'h00 : {6'h00, ext_pin_q, in_pin_q};
      default:      rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  chk_ovf_wraps_flag: assert property ((cnt_inc && !cnt_wr && cnt_r == CNT_MAX)
    |=> (cnt_r == CNT_RST && flags_r[FLAG_OVF]))
    else $error("overflow did not wrap and flag");
  chk_off_holds_cnt: assert property ((!ctrl_r[CTRL_ON] && !reg_wr) |=> $stable(cnt_r))
    else $error("counter moved while stopped");
  chk_instr_tick_rate: assert property (instr_tick |=> !instr_tick [*3] ##1 instr_tick)
    else $error("instruction tick not one in four");
  chk_int_src_only: assert property ((cnt_inc && !ctrl_r[CTRL_SRC]) |-> instr_tick)
    else $error("internal count off instruction tick");
  chk_sync_delay: assert property ((ctrl_r[CTRL_SRC] && !ctrl_r[CTRL_NOSYNC] && ext_rise
    && $stable(ctrl_r)) |-> $past(ext_pin_q, 2) && !$past(ext_pin_q, 3))
    else $error("synchronised edge not two stages late");
  chk_osc_pins_input: assert property (ctrl_r[CTRL_OSCEN]
    |=> !sec_osc_in_pin_oe && !sec_osc_out_ext_clk_pin_oe)
    else $error("oscillator pins still driven");
  chk_port_reads_zero: assert property ((reg_rd && reg_addr == ADDR_PDATA
    && ctrl_r[CTRL_OSCEN]) |=> reg_rdata == 8'h00)
    else $error("oscillator pins read nonzero");
  chk_wide_read_latch: assert property ((rd_lo && wide && !wr_hi)
    |=> hibuf_r == $past(cnt_r[15:8]))
    else $error("low read did not latch high byte");
  chk_wide_write_load: assert property ((wr_lo && wide)
    |=> cnt_r == {$past(hibuf_r), $past(reg_wdata)})
    else $error("wide write did not load both bytes");
  chk_hi_keeps_psc: assert property ((wr_hi && !src_tick) |=> $stable(u_psc.cnt_r))
    else $error("high write cleared prescaler");
  chk_secondary_run_mode_entry: assert property ((mode_r == TSC_PRI_RUN && wr_osc
    && reg_wdata[1:0] == SCS_SEC) |=> mode_r == TSC_SECONDARY_RUN_MODE ##1 sec_osc_is_sysclk)
    else $error("clock select did not enter secondary run");
  chk_secondary_idle_mode_entry: assert property ((mode_r == TSC_SECONDARY_RUN_MODE && sleep_exec && !fail_evt
    && !wr_osc && !osc_r[OSC_IDLE]) |=> mode_r == TSC_SECONDARY_IDLE_MODE)
    else $error("sleep did not enter secondary idle");
  chk_fail_status: assert property ((mode_r != TSC_PRI_RUN && fail_evt)
    |=> ##1 !sec_osc_is_sysclk)
    else $error("status still shows failed oscillator");
  chk_amp_in_sleep: assert property ((sleep_exec && !wr_ctrl) |=> ##1
    sec_osc_amp_en == $past(ctrl_r[CTRL_OSCEN], 2))
    else $error("sleep disturbed oscillator enable");
  chk_irq_gate: assert property ((flags_r[FLAG_OVF] && enables_r[FLAG_OVF]) |=> irq)
    else $error("enabled flag raised no interrupt");

  cov_overflow: cover property (ovf_evt ##[1:20] irq);
  cov_wide_pair: cover property (rd_lo && wide ##1 reg_rd && reg_addr == ADDR_CNT_HI);
  cov_idle_wake: cover property (mode_r == TSC_SECONDARY_IDLE_MODE ##[1:50] mode_r == TSC_SECONDARY_RUN_MODE);
  cov_ext_count: cover property (cnt_inc && ctrl_r[CTRL_SRC]);

endmodule

// file: sim/tsc_xtal_model.sv
/*
  Far side of the counter: external count clock and crystal pins.
  Assumes the bench raises go with an edge count n and lowers it after.
*/
module tsc_xtal_model (
  input  wire logic       go,
  input  wire logic [7:0] n,
  output logic            ext_pin,
  output logic            in_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // Burst of n rising edges, 200 ns period, still between bursts
  // ------------------------------------------------------------
  initial begin
    ext_pin = 1'b0;
    forever begin
      wait (go);
      #37;
      repeat (n) begin
        #100 ext_pin = 1'b1;
        #100 ext_pin = 1'b0;
      end
      wait (!go);
    end
  end
  // Crystal input swings opposite to the amplifier side
  assign in_pin = ~ext_pin;
endmodule

// file: sim/tsc_top_tb.sv
/*
  Self-checking bench for the secondary-oscillator timer.
  Assumes the register port, pin model and power-mode timing of the design.
*/
module tsc_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import tsc_pkg::*;
  logic       core_clk, nrst, reg_wr, reg_rd, sleep_exec, fscm_enable, sec_osc_fail, go;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, n, d;
  logic       in_o, in_oe, ext_o, ext_oe, amp_en, irq, sysclk, in_m, ext_m;
  tsc_mode_t  power_mode;
  int         fail_count, n_checks, cyc;
  // Wire level of each shared pin
  wire in_w  = in_oe ? in_o : in_m;
  wire ext_w = ext_oe ? ext_o : ext_m;

  tsc_top uut (.core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .sleep_exec, .fscm_enable, .sec_osc_fail, .sec_osc_in_pin_i(in_w),
    .sec_osc_in_pin_o(in_o), .sec_osc_in_pin_oe(in_oe), .sec_osc_out_ext_clk_pin_i(ext_w),
    .sec_osc_out_ext_clk_pin_o(ext_o), .sec_osc_out_ext_clk_pin_oe(ext_oe),
    .sec_osc_amp_en(amp_en), .irq(irq), .sec_osc_is_sysclk(sysclk), .power_mode);
  tsc_xtal_model xtal (.go, .n, .ext_pin(ext_m), .in_pin(in_m));

  // ------------------------------------------------------------
  // Clock, timeout and access tasks
  // ------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Cuts a hang short
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge core_clk);
  endtask
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic rchk(input string s, input logic [2:0] a, input logic [7:0] e);
    rd(a, d);
    chk(s, e, d);
  endtask
  task automatic chkm(input tsc_mode_t e);
    n_checks++;
    if (power_mode !== e) begin
      fail_count++;
      $display("wrong value power_mode expected %h seen %h", e, power_mode);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    {nrst, reg_wr, reg_rd, sleep_exec, fscm_enable, sec_osc_fail, go} = '0;
    {reg_addr, reg_wdata, n, cyc, fail_count, n_checks} = '0;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    rchk("ctrl reset", ADDR_CTRL, CTRL_RST);
    rchk("pdir reset", ADDR_PDIR, 8'h03);
    rchk("flags reset", ADDR_FLAGS, FLAGS_RST);
    wr(ADDR_CTRL, 8'hff);
    rchk("ctrl ro", ADDR_CTRL, 8'hbf);
    wr(ADDR_CTRL, 8'h00);
    $display("test registers done");
    // Ten prescaled ticks from fffb end at 0005 with one overflow
    wr(ADDR_ENABLES, 8'h01);
    for (int ps = 0; ps < 4; ps++) begin
      wr(ADDR_CNT_HI, 8'hff);
      wr(ADDR_CNT_LO, 8'hfb);
      wr(ADDR_CTRL, {2'h0, ps[1:0], 4'h5});
      repeat ((40 << ps) - 2) @(posedge core_clk);
      wr(ADDR_CTRL, 8'h00);
      repeat (4) @(posedge core_clk);
      rchk("count low", ADDR_CNT_LO, 8'h05);
      rchk("count high", ADDR_CNT_HI, 8'h00);
      chk("irq", 8'h01, {7'h0, irq});
      rchk("flags", ADDR_FLAGS, 8'h01);
      rchk("flags clear", ADDR_FLAGS, 8'h00);
    end
    wr(ADDR_ENABLES, 8'h00);
    repeat (50) @(posedge core_clk);
    rchk("count held", ADDR_CNT_LO, 8'h05);
    $display("test internal count done");
    wr(ADDR_CTRL, 8'h80);
    wr(ADDR_CNT_HI, 8'h12);
    wr(ADDR_CNT_LO, 8'h34);
    wr(ADDR_CNT_HI, 8'h56);
    rchk("buffer", ADDR_CNT_HI, 8'h56);
    rchk("wide low", ADDR_CNT_LO, 8'h34);
    rchk("wide high", ADDR_CNT_HI, 8'h12);
    $display("test wide access done");
    // External edges, synchronised then bypassed
    for (int s = 0; s < 2; s++) begin
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_CNT_HI, 8'h00);
      wr(ADDR_CNT_LO, 8'h00);
      wr(ADDR_CTRL, {5'h0, s[0], 2'h3});
      n  <= 8'd6;
      go <= 1'b1;
      repeat (70) @(posedge core_clk);
      go <= 1'b0;
      wr(ADDR_CTRL, 8'h00);
      rchk("ext count", ADDR_CNT_LO, 8'h06);
    end
    $display("test external count done");
    rchk("pins", ADDR_PDATA, 8'h01);
    wr(ADDR_PDIR, 8'h00);
    wr(ADDR_PDATA, 8'h02);
    repeat (2) @(posedge core_clk);
    #1 chk("pin drive", 8'h0b, {4'h0, ext_o, in_o, ext_oe, in_oe});
    wr(ADDR_CTRL, 8'h08);
    repeat (2) @(posedge core_clk);
    #1 chk("osc pins", 8'h04, {5'h0, amp_en, ext_oe, in_oe});
    rchk("pins zero", ADDR_PDATA, 8'h00);
    $display("test pins done");
    wr(ADDR_OSC, 8'h01);
    @(posedge core_clk);
    #1 chkm(TSC_SECONDARY_RUN_MODE);
    rchk("run status", ADDR_CTRL, 8'h48);
    sleep_exec <= 1'b1;
    @(posedge core_clk);
    sleep_exec <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 chkm(TSC_SECONDARY_IDLE_MODE);
    chk("amp idle", 8'h03, {6'h0, sysclk, amp_en});
    fscm_enable  <= 1'b1;
    sec_osc_fail <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1 chkm(TSC_PRI_RUN);
    rchk("fail status", ADDR_CTRL, 8'h08);
    // Idle-on-sleep set keeps secondary run; a new select returns to primary
    fscm_enable  <= 1'b0;
    sec_osc_fail <= 1'b0;
    wr(ADDR_OSC, 8'h81);
    sleep_exec <= 1'b1;
    @(posedge core_clk);
    sleep_exec <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 chkm(TSC_SECONDARY_RUN_MODE);
    rchk("osc reg", ADDR_OSC, 8'h81);
    wr(ADDR_OSC, 8'h00);
    @(posedge core_clk);
    #1 chkm(TSC_PRI_RUN);
    $display("test power modes done");
    test_done();
  end
endmodule
